//--- bench/tb_uart_multiproc_serial.sv
// testbench: transmit burst through the fifo and receive acceptance against a model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_uart_multiproc_serial;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic       tx_fifo_ready;
   logic       rxd;
   logic       txd_o;
   logic       rxd_o;
   logic       rxd_oe_n;
   logic       irq;
   int         errors = 0;
   int         samples_checked = 0;
   int         seed = 32'h077112AB;
   logic [7:0] rv;
   logic [7:0] bf = 8'h00;
   logic [7:0] sa = 8'h00;
   logic [7:0] mk = 8'h00;
   logic       fe = 1'b0;
   logic [8:0] exp_q[$];
   always #25 clk_sys = ~clk_sys;
   usp_serial dut (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tx_fifo_ready(tx_fifo_ready), .rxd_i(rxd),
      .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .txd_o(txd_o), .serial_irq(irq));
   usp_remote far (.clk_sys(clk_sys), .txd(txd_o), .rxd(rxd), .sdata(rxd_o), .sdata_oe_n(rxd_oe_n));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      rv = sfr_rdata;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // frame error select stays on in the loop so bit 7 writes reach the error flag, not the mode
   task automatic run_rx(input logic [1:0] md, input logic dbl, input int bc);
      logic       ri, mp, dec, acc, stp, nth;
      logic [7:0] d;
      wr(usp_pkg::ADDR_POWER_CONTROL, {dbl, 7'h00});
      wr(usp_pkg::ADDR_SERIAL_CONTROL, {md, 6'h10});
      wr(usp_pkg::ADDR_POWER_CONTROL, {dbl, 7'h40});
      ri = 1'b0;
      far.bit_clks = bc;
      for (int i = 0; i < 8; i++) begin
         if (i % 3 == 2) begin
            sa = 8'($random(seed));
            mk = 8'($random(seed));
            wr(usp_pkg::ADDR_STATION_ADDRESS, sa);
            wr(usp_pkg::ADDR_STATION_MASK, mk);
         end
         mp = 1'($random(seed));
         nth = 1'($random(seed));
         stp = ($random(seed) % 4) != 0;
         d = (i % 2) ? 8'($random(seed)) : ((i % 4) ? (sa | mk) : sa);
         if (i == 5) fe = 1'b0;
         ri = ri & 1'($random(seed));
         wr(usp_pkg::ADDR_SERIAL_CONTROL, {fe, md[0], mp, 1'b1, 3'h0, ri});
         dec = (md == 2'h1) ? stp : nth;
         far.send(d, dec, stp, (md == 2'h1) ? 10 : 11);
         acc = !ri && (!mp || (dec && ((((d ^ sa) & mk) == 8'h00) || ((d & (sa | mk)) == (sa | mk)))));
         if (acc) begin
            ri = 1'b1;
            bf = d;
         end
         fe = fe | !stp;
         rd(usp_pkg::ADDR_SERIAL_CONTROL);
         `CHK(rv[0], ri)
         `CHK(rv[7], fe)
         if (acc) `CHK(rv[2], dec)
         `CHK(irq, ri)
         rd(usp_pkg::ADDR_SERIAL_BUFFER);
         `CHK(rv, bf)
      end
      $display("test receive mode %0d doubler %0d finished", md, dbl);
   endtask
   initial begin
      repeat (3) @(negedge clk_sys);
      rstn = 1'b1;
      rd(usp_pkg::ADDR_STATION_ADDRESS);
      `CHK(rv, 8'h00)
      rd(usp_pkg::ADDR_STATION_MASK);
      `CHK(rv, 8'h00)
      rd(8'h55);
      `CHK(rv, 8'h00)
      wr(usp_pkg::ADDR_POWER_CONTROL, 8'h80);
      wr(usp_pkg::ADDR_SERIAL_CONTROL, 8'h98);
      far.bit_clks = 32;
      for (int i = 0; i < 18; i++) begin
         rv = 8'($random(seed));
         wr(usp_pkg::ADDR_SERIAL_BUFFER, rv);
         if (i < 17) exp_q.push_back({1'b1, rv});
      end
      `CHK(tx_fifo_ready, 1'b0)
      for (int n = 0; n < 9000 && far.got_q.size() < 17; n++) @(negedge clk_sys);
      // let the last stop bit finish so its done flag cannot land inside the receive tests
      repeat (2 * far.bit_clks) @(negedge clk_sys);
      `CHK(far.got_q.size(), 17)
      for (int i = 0; i < 17; i++) `CHK(far.got_q[i], exp_q[i])
      rd(usp_pkg::ADDR_SERIAL_CONTROL);
      `CHK(rv[1], 1'b1)
      `CHK(tx_fifo_ready, 1'b1)
      wr(usp_pkg::ADDR_SERIAL_CONTROL, 8'h98);
      rd(usp_pkg::ADDR_SERIAL_CONTROL);
      `CHK(rv[1], 1'b0)
      `CHK(irq, 1'b0)
      $display("test transmit burst finished");
      // timer 1 fast prescale with top reload: one overflow every four clocks
      wr(usp_pkg::ADDR_CLOCK_SETUP, 8'h10);
      wr(usp_pkg::ADDR_TIMER1_RELOAD, 8'hFF);
      run_rx(2'h2, 1'b1, 32);
      run_rx(2'h2, 1'b0, 64);
      run_rx(2'h3, 1'b1, 64);
      run_rx(2'h1, 1'b1, 64);
      // mode 0 shift out, fast then slow shift clock
      wr(usp_pkg::ADDR_POWER_CONTROL, 8'h00);
      for (int k = 0; k < 2; k++) begin
         int per;
         per = (k == 0) ? usp_pkg::M0_DIV_FAST : usp_pkg::M0_DIV_SLOW;
         wr(usp_pkg::ADDR_SERIAL_CONTROL, {2'h0, k == 0, 5'h00});
         far.m0_cnt = 0;
         rv = 8'($random(seed));
         wr(usp_pkg::ADDR_SERIAL_BUFFER, rv);
         repeat (16 * usp_pkg::M0_DIV_SLOW) @(negedge clk_sys);
         `CHK(far.m0_cnt, 8)
         `CHK(far.m0_sh, rv)
         `CHK((far.m0_t_last - far.m0_t_first) / 50, 7 * per)
         `CHK(rxd_oe_n, 1'b1)
         rd(usp_pkg::ADDR_SERIAL_CONTROL);
         `CHK(rv[1], 1'b1)
      end
      $display("test mode 0 shift finished");
      complete_run;
   end
   initial begin
      repeat (80000) @(posedge clk_sys);
      errors++;
      complete_run;
   end
endmodule
`default_nettype wire

//--- bench/usp_remote.sv
// remote station model: drives the receive line and captures transmitted frames
`timescale 1ns/1ps
`default_nettype none
module usp_remote (
   input  wire logic clk_sys,
   input  wire logic txd,
   output logic      rxd,
   input  wire logic sdata,
   input  wire logic sdata_oe_n
);
   int         bit_clks = 64;
   logic [8:0] got_q[$];
   logic [8:0] sh;
   int         m0_cnt = 0;
   logic [7:0] m0_sh;
   time        m0_t_first;
   time        m0_t_last;
   initial rxd = 1'b1;
   // ninth carries the address marker or, for ten-bit frames, the stop level
   task automatic send(input logic [7:0] d, input logic ninth, input logic stop, input int nbits);
      logic [10:0] f;
      f = {stop, ninth, d, 1'b0};
      for (int i = 0; i < nbits; i++) begin
         rxd = f[i];
         repeat (bit_clks) @(negedge clk_sys);
      end
      rxd = 1'b1;
      repeat (2 * bit_clks) @(negedge clk_sys);
   endtask
   // sample at bit centres; async frames sent towards us carry nine bits, mode 0 shifts are taken below
   always begin
      @(negedge txd);
      repeat (bit_clks / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++) begin
         repeat (bit_clks) @(posedge clk_sys);
         sh[i] = txd;
      end
      got_q.push_back(sh);
      repeat (bit_clks) @(posedge clk_sys);
   end
   // mode 0 slave: data is stable at each rising shift clock while the line is driven
   always @(posedge txd) begin
      if (!sdata_oe_n) begin
         m0_sh = {sdata, m0_sh[7:1]};
         if (m0_cnt == 0) m0_t_first = $time;
         m0_t_last = $time;
         m0_cnt++;
      end
   end
endmodule
`default_nettype wire

//--- design/usp_pkg.sv
// package: register map, field positions and timing constants of the serial port
package usp_pkg;
   // register addresses on the special function register port
   localparam logic [7:0] ADDR_POWER_CONTROL    = 8'h87;
   localparam logic [7:0] ADDR_TIMER1_RELOAD    = 8'h8D;
   localparam logic [7:0] ADDR_CLOCK_SETUP      = 8'h8E;
   localparam logic [7:0] ADDR_SERIAL_CONTROL   = 8'h98;
   localparam logic [7:0] ADDR_SERIAL_BUFFER    = 8'h99;
   localparam logic [7:0] ADDR_STATION_ADDRESS  = 8'hA9;
   localparam logic [7:0] ADDR_STATION_MASK     = 8'hB9;

   // serial_control fields
   localparam int SC_MODE_HIGH = 7;
   localparam int SC_MODE_LOW  = 6;
   localparam int SC_MP_EN     = 5;
   localparam int SC_RX_EN     = 4;
   localparam int SC_TX_NINTH  = 3;
   localparam int SC_RX_NINTH  = 2;
   localparam int SC_TX_DONE   = 1;
   localparam int SC_RX_DONE   = 0;
   // power_control and clock_setup fields
   localparam int PC_DOUBLER   = 7;
   localparam int PC_FE_SELECT = 6;
   localparam int CK_T1_FAST   = 4;

   localparam logic [7:0] RESET_BYTE = 8'h00;

   // mode encoding of {mode_select_high, mode_select_low}
   typedef enum logic [1:0] {
      USP_MODE0 = 2'h0,
      USP_MODE1 = 2'h1,
      USP_MODE2 = 2'h2,
      USP_MODE3 = 2'h3
   } usp_mode_t;

   // timing
   localparam int OVERSAMPLE      = 16;
   localparam int M2_DIV_SLOW     = 64;
   localparam int M2_DIV_FAST     = 32;
   localparam int M0_DIV_SLOW     = 12;
   localparam int M0_DIV_FAST     = 4;
   localparam int T1_PRE_SLOW     = 12;
   localparam int T1_PRE_FAST     = 4;
   localparam int M2_TICK_SLOW    = M2_DIV_SLOW / OVERSAMPLE;
   localparam int M2_TICK_FAST    = M2_DIV_FAST / OVERSAMPLE;
   localparam int M0_HALF_SLOW    = M0_DIV_SLOW / 2;
   localparam int M0_HALF_FAST    = M0_DIV_FAST / 2;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] BIT_LAST   = 4'hF;
   localparam logic [2:0] DATA_LAST  = 3'h7;
   localparam logic [3:0] FRAME_M1   = 4'hA;
   localparam logic [3:0] FRAME_M23  = 4'hB;
   localparam logic [3:0] FRAME_M0   = 4'h8;
   localparam logic [7:0] T1_TOP     = 8'hFF;
endpackage

//--- design/usp_serial.sv
// serial port with multiprocessor address recognition, plus its transmit FIFO
// Function
// - mode 1 accepts at mid stop if rx done clear and (no mp or stop=1)
// - mode 1 accept loads buffer, stop into rx ninth, sets rx done; reject loads nothing
// - after each attempt receiver waits for a fresh falling edge on rxd
// - modes 2/3 frame: start low, 8 data lsb first, ninth bit, stop high
// - mode 2 bit rate is clock/64, or clock/32 with doubler
// - modes 2/3 buffer write sends frame; tx done set when stop driven
// - modes 2/3 accept at mid ninth if rx done clear and (no mp or ninth=1)
// - modes 2/3 accept loads buffer, ninth bit, sets rx done; reject loads nothing
// - mode 3 equals mode 2 except bit rate comes from timer 1 overflow
// - modes 1/3 rate is 2^doubler/32 of clock/(12 or 4 times (256-reload))
// - mode 0 shift rate is clock/12, or clock/4 with mp enable
// - modes 1-3 set framing error when stop bit is not high
// - framing error flag and mode high bit share a position, stored apart
// - framing error stays set until software writes it clear
// - modes 2/3 with mp enable ignore frames whose ninth bit is 0
// - mp enable selects the mode 0 shift rate; in mode 1 needs valid stop
// - with mp enable rx done only for given or broadcast address match
// - mode 1 address recognition uses stop bit in place of ninth bit
// - given address: station address under mask, zero mask bits don't care
// - broadcast: or of address and mask, ones must match, zeros don't care
// - reset zeroes address and mask so every address is recognised
// - tx done set by hardware as stop bit goes out (mode 0 after last bit), cleared only by software
// - mode bits 00 sync, 01 10-bit async, 10 and 11 11-bit async
`timescale 1ns/1ps
`default_nettype none

module usp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // elaboration refuses depths that the wrapping pointers cannot count
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("usp_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;
   assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
   assign out_valid = wr_ptr_r != rd_ptr_r;
   assign out_data  = mem[rd_ptr_r[AW-1:0]];
   always_ff @(posedge clk_sys) begin
      if (push) mem[wr_ptr_r[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      end
   end
endmodule

module usp_serial #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            tx_fifo_ready,
   input  wire logic       rxd_i,
   output logic            rxd_o,
   output logic            rxd_oe_n,
   output logic            txd_o,
   output logic            serial_irq
);
   if (FIFO_DEPTH < 2) begin : g_depth_check
      $error("usp_serial needs a fifo depth of at least two");
   end

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b011,
      RX_NINTH = 3'b010,
      RX_STOP  = 3'b110
   } usp_rx_state_t;

   // ---------------- registers ----------------
   logic       mode_high_r, mode_low_r, mp_en_r, rx_en_r, tx_ninth_r, rx_ninth_r;
   logic       tx_done_r, rx_done_r, fe_r, doubler_r, fe_sel_r, t1_fast_r;
   logic [7:0] t1_reload_r, station_addr_r, station_mask_r, rx_buf_r, rdata_r;

   wire wr_ctrl   = sfr_wr && (sfr_addr == usp_pkg::ADDR_SERIAL_CONTROL);
   wire wr_buf    = sfr_wr && (sfr_addr == usp_pkg::ADDR_SERIAL_BUFFER);
   wire wr_power  = sfr_wr && (sfr_addr == usp_pkg::ADDR_POWER_CONTROL);
   wire wr_clock  = sfr_wr && (sfr_addr == usp_pkg::ADDR_CLOCK_SETUP);
   wire wr_reload = sfr_wr && (sfr_addr == usp_pkg::ADDR_TIMER1_RELOAD);
   wire wr_addr   = sfr_wr && (sfr_addr == usp_pkg::ADDR_STATION_ADDRESS);
   wire wr_mask   = sfr_wr && (sfr_addr == usp_pkg::ADDR_STATION_MASK);

   wire usp_pkg::usp_mode_t mode = usp_pkg::usp_mode_t'({mode_high_r, mode_low_r});
   wire mode0  = (mode == usp_pkg::USP_MODE0);
   wire mode1  = (mode == usp_pkg::USP_MODE1);
   wire mode2  = (mode == usp_pkg::USP_MODE2);
   wire mode3  = (mode == usp_pkg::USP_MODE3);
   wire nine_b = mode2 || mode3;

   // ---------------- bit rate generation ----------------
   logic [3:0] pre_cnt_r, div_cnt_r;
   logic [7:0] t1_cnt_r;
   logic       t1_half_r;
   wire [3:0] pre_lim = t1_fast_r ? 4'(usp_pkg::T1_PRE_FAST - 1) : 4'(usp_pkg::T1_PRE_SLOW - 1);
   wire       t1_en   = (pre_cnt_r == pre_lim);
   wire       t1_ovf  = t1_en && (t1_cnt_r == usp_pkg::T1_TOP);
   // overflow/32 per bit is overflow/2 per sixteenth; doubler skips the halving
   wire       t1_tick = t1_ovf && (doubler_r || t1_half_r);
   wire [3:0] m2_lim  = doubler_r ? 4'(usp_pkg::M2_TICK_FAST - 1) : 4'(usp_pkg::M2_TICK_SLOW - 1);
   wire [3:0] m0_lim  = mp_en_r ? 4'(usp_pkg::M0_HALF_FAST - 1) : 4'(usp_pkg::M0_HALF_SLOW - 1);
   wire [3:0] div_lim = mode0 ? m0_lim : m2_lim;
   wire       div_tick = (div_cnt_r >= div_lim);
   wire       tick16  = mode2 ? div_tick : (t1_tick && (mode1 || mode3));

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pre_cnt_r <= '0;
         div_cnt_r <= '0;
         t1_cnt_r  <= usp_pkg::RESET_BYTE;
         t1_half_r <= 1'b0;
      end else begin
         pre_cnt_r <= t1_en ? 4'h0 : pre_cnt_r + 4'h1;
         div_cnt_r <= div_tick ? 4'h0 : div_cnt_r + 4'h1;
         if (t1_en) t1_cnt_r <= t1_ovf ? t1_reload_r : t1_cnt_r + 8'h01;
         if (t1_ovf) t1_half_r <= ~t1_half_r;
      end
   end

   // ---------------- receiver ----------------
   usp_rx_state_t rx_state_r;
   logic [3:0] rx_ovs_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_shift_r;
   logic       rxd_prev_r, rx_pend_r;

   wire rx_fall = rxd_prev_r && !rxd_i && rx_en_r && !mode0;
   wire rx_mid  = tick16 && (rx_ovs_r == usp_pkg::SAMPLE_MID);
   // given address: masked bits must equal; broadcast: set bits of the or must be one
   wire [7:0] given_diff = (rx_shift_r ^ station_addr_r) & station_mask_r;
   wire [7:0] bcast      = station_addr_r | station_mask_r;
   wire       addr_ok    = (given_diff == 8'h00) || ((rx_shift_r & bcast) == bcast);
   wire       decide_m1  = rx_mid && (rx_state_r == RX_STOP) && mode1;
   wire       decide_m23 = rx_mid && (rx_state_r == RX_NINTH);
   wire       rx_decide  = decide_m1 || decide_m23;
   // in mode 1 the stop bit stands in for the ninth bit
   wire       rx_accept  = rx_decide && !rx_done_r && (!mp_en_r || (rxd_i && addr_ok));
   wire       rx_reject  = rx_decide && !rx_accept;
   wire       rx_fe_set  = rx_mid && (rx_state_r == RX_STOP) && !rxd_i;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_state_r <= RX_IDLE;
         rx_ovs_r   <= '0;
         rx_bit_r   <= '0;
         rx_shift_r <= usp_pkg::RESET_BYTE;
         rxd_prev_r <= 1'b1;
      end else begin
         rxd_prev_r <= rxd_i;
         if (tick16) rx_ovs_r <= rx_ovs_r + 4'h1;
         case (rx_state_r)
            RX_IDLE: begin
               if (rx_fall) begin
                  rx_state_r <= RX_START;
                  rx_ovs_r   <= '0;
               end
            end
            RX_START: begin
               if (rx_mid) rx_state_r <= rxd_i ? RX_IDLE : RX_DATA;
               rx_bit_r <= '0;
            end
            RX_DATA: begin
               if (rx_mid) begin
                  rx_shift_r <= {rxd_i, rx_shift_r[7:1]};
                  rx_bit_r   <= rx_bit_r + 3'h1;
                  if (rx_bit_r == usp_pkg::DATA_LAST) rx_state_r <= nine_b ? RX_NINTH : RX_STOP;
               end
            end
            RX_NINTH: begin
               if (rx_mid) rx_state_r <= RX_STOP;
            end
            RX_STOP: begin
               if (rx_mid) rx_state_r <= RX_IDLE;
            end
            default: rx_state_r <= RX_IDLE;
         endcase
         if (!rx_en_r || mode0) rx_state_r <= RX_IDLE;
      end
   end

   // ---------------- transmitter ----------------
   logic       tx_busy_r, m0_phase_r, txd_r, rxd_out_r;
   logic [3:0] tx_ovs_r, tx_cnt_r;
   logic [10:0] tx_sh_r;
   wire        fifo_valid;
   wire [7:0]  fifo_data;
   wire [3:0]  frame_len = mode0 ? usp_pkg::FRAME_M0 : (nine_b ? usp_pkg::FRAME_M23 : usp_pkg::FRAME_M1);
   wire        tx_load   = !tx_busy_r && fifo_valid;
   wire        bit_tick  = mode0 ? (div_tick && m0_phase_r) : (tick16 && tx_ovs_r == usp_pkg::BIT_LAST);
   wire        tx_next   = tx_busy_r && bit_tick;
   wire        tx_last   = tx_cnt_r == frame_len - 4'h1;
   // async modes flag as the stop bit goes out, mode 0 after the eighth bit
   wire        tx_done_set = tx_next && (mode0 ? tx_last : (tx_cnt_r == frame_len - 4'h2));

   usp_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  (wr_buf),
      .in_ready  (tx_fifo_ready),
      .in_data   (sfr_wdata),
      .out_valid (fifo_valid),
      .out_ready (tx_load),
      .out_data  (fifo_data)
   );

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         tx_busy_r  <= 1'b0;
         m0_phase_r <= 1'b0;
         tx_ovs_r   <= '0;
         tx_cnt_r   <= '0;
         tx_sh_r    <= '1;
         txd_r      <= 1'b1;
         rxd_out_r  <= 1'b1;
      end else if (tx_load) begin
         tx_busy_r <= 1'b1;
         tx_ovs_r  <= '0;
         tx_cnt_r  <= '0;
         m0_phase_r <= 1'b0;
         if (mode0) begin
            tx_sh_r   <= {3'b111, fifo_data};
            rxd_out_r <= fifo_data[0];
            txd_r     <= 1'b0;
         end else begin
            // stop (never reached in mode 1), ninth (mode 1 sends its stop level here), data, start
            tx_sh_r <= {1'b1, nine_b ? tx_ninth_r : 1'b1, fifo_data, 1'b0};
            txd_r   <= 1'b0;
         end
      end else if (tx_busy_r) begin
         if (tick16) tx_ovs_r <= tx_ovs_r + 4'h1;
         if (mode0 && div_tick) begin
            m0_phase_r <= ~m0_phase_r;
            txd_r      <= ~m0_phase_r; // shift clock high in the second half
         end
         if (tx_next) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            if (tx_last) begin
               tx_busy_r <= 1'b0;
               txd_r     <= 1'b1;
               rxd_out_r <= 1'b1;
            end else if (mode0) begin
               rxd_out_r <= tx_sh_r[1];
               txd_r     <= 1'b0;
            end else begin
               txd_r <= tx_sh_r[1];
            end
         end
      end
   end
   assign txd_o    = txd_r;
   assign rxd_o    = rxd_out_r;
   assign rxd_oe_n = !(tx_busy_r && mode0);

   // ---------------- register file ----------------
   wire ctrl_high_sel = fe_sel_r ? fe_r : mode_high_r;
   wire [7:0] ctrl_rd = {ctrl_high_sel, mode_low_r, mp_en_r, rx_en_r, tx_ninth_r, rx_ninth_r, tx_done_r, rx_done_r};
   wire [7:0] rd_mux =
      (sfr_addr == usp_pkg::ADDR_SERIAL_CONTROL)  ? ctrl_rd :
      (sfr_addr == usp_pkg::ADDR_SERIAL_BUFFER)   ? rx_buf_r :
      (sfr_addr == usp_pkg::ADDR_POWER_CONTROL)   ? {doubler_r, fe_sel_r, 6'h00} :
      (sfr_addr == usp_pkg::ADDR_CLOCK_SETUP)     ? {3'h0, t1_fast_r, 4'h0} :
      (sfr_addr == usp_pkg::ADDR_TIMER1_RELOAD)   ? t1_reload_r :
      (sfr_addr == usp_pkg::ADDR_STATION_ADDRESS) ? station_addr_r :
      (sfr_addr == usp_pkg::ADDR_STATION_MASK)    ? station_mask_r : 8'h00;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         {mode_high_r, mode_low_r, mp_en_r, rx_en_r, tx_ninth_r} <= '0;
         {rx_ninth_r, tx_done_r, rx_done_r, fe_r} <= '0;
         {doubler_r, fe_sel_r, t1_fast_r} <= '0;
         t1_reload_r    <= usp_pkg::RESET_BYTE;
         station_addr_r <= usp_pkg::RESET_BYTE;
         station_mask_r <= usp_pkg::RESET_BYTE;
         rx_buf_r       <= usp_pkg::RESET_BYTE;
         rdata_r        <= usp_pkg::RESET_BYTE;
      end else begin
         if (sfr_rd) rdata_r <= rd_mux;
         if (wr_ctrl) begin
            if (!fe_sel_r) mode_high_r <= sfr_wdata[usp_pkg::SC_MODE_HIGH];
            mode_low_r <= sfr_wdata[usp_pkg::SC_MODE_LOW];
            mp_en_r    <= sfr_wdata[usp_pkg::SC_MP_EN];
            rx_en_r    <= sfr_wdata[usp_pkg::SC_RX_EN];
            tx_ninth_r <= sfr_wdata[usp_pkg::SC_TX_NINTH];
         end
         // hardware set wins over a software clear in the same cycle
         if (rx_accept) rx_ninth_r <= rxd_i;
         else if (wr_ctrl) rx_ninth_r <= sfr_wdata[usp_pkg::SC_RX_NINTH];
         rx_done_r <= rx_accept || (wr_ctrl ? sfr_wdata[usp_pkg::SC_RX_DONE] : rx_done_r);
         tx_done_r <= tx_done_set || (wr_ctrl ? sfr_wdata[usp_pkg::SC_TX_DONE] : tx_done_r);
         fe_r <= rx_fe_set || ((wr_ctrl && fe_sel_r) ? sfr_wdata[usp_pkg::SC_MODE_HIGH] : fe_r);
         if (rx_accept) rx_buf_r <= rx_shift_r;
         if (wr_power) begin
            doubler_r <= sfr_wdata[usp_pkg::PC_DOUBLER];
            fe_sel_r  <= sfr_wdata[usp_pkg::PC_FE_SELECT];
         end
         if (wr_clock) t1_fast_r <= sfr_wdata[usp_pkg::CK_T1_FAST];
         if (wr_reload) t1_reload_r <= sfr_wdata;
         if (wr_addr) station_addr_r <= sfr_wdata;
         if (wr_mask) station_mask_r <= sfr_wdata;
      end
   end
   assign sfr_rdata  = rdata_r;
   assign serial_irq = rx_done_r || tx_done_r;

   // ---------------- checks ----------------
   chk_accept_loads_buffer: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_accept |=> rx_done_r && rx_buf_r == $past(rx_shift_r))
      else $error("accepted frame did not load buffer");
   chk_reject_keeps_buffer: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_reject |=> rx_buf_r == $past(rx_buf_r))
      else $error("rejected frame changed buffer");
   chk_mp_ninth_block: assert property (@(posedge clk_sys) disable iff (!rstn)
      (decide_m23 && mp_en_r && !rxd_i) |-> !rx_accept)
      else $error("ninth bit zero frame accepted under mp enable");
   chk_fe_stays_set: assert property (@(posedge clk_sys) disable iff (!rstn)
      (fe_r && !(wr_ctrl && fe_sel_r)) |=> fe_r)
      else $error("framing error cleared without software");
   chk_stop_back_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rx_state_r == RX_STOP && rx_mid) |=> rx_state_r == RX_IDLE ##1 rx_state_r != RX_DATA)
      else $error("receiver did not return to idle after stop");
   chk_start_bit_low: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_load && !mode0) |=> !txd_o && tx_busy_r)
      else $error("frame did not begin with a low start bit");
   chk_tx_done_raise: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_done_set && !mode0) |=> tx_done_r && txd_o)
      else $error("tx done not set with stop bit on the line");
   chk_reset_addr_open: assert property (@(posedge clk_sys) disable iff (!rstn)
      (station_addr_r == 8'h00 && station_mask_r == 8'h00) |-> addr_ok)
      else $error("zeroed address registers filtered an address");
   chk_t1_reload: assert property (@(posedge clk_sys) disable iff (!rstn)
      t1_ovf |=> t1_cnt_r == $past(t1_reload_r))
      else $error("timer did not reload after overflow");
   chk_m2_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rstn)
      (mode2 && !doubler_r && div_tick && !sfr_wr) |=> !div_tick)
      else $error("mode 2 sample tick too fast");
   chk_fe_low_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_fe_set |=> fe_r)
      else $error("low stop bit did not set framing error");
endmodule

`default_nettype wire
